// File: core/wrp_wake_signaler.sv
// Wake request pin signaler with AXI4-Lite register slave
`timescale 1ns/1ps

// Function
// R1: Assert wake only with master enable set
// R2: Any enabled wake source asserts wake
// R3: Master off ignores all other settings
// R4: Bit 6 picks level or pulse signalling
// R5: Bit 5 picks 1.5 ms or 150 ms
// R6: Pulse timed from first event, not extended
// R7: Bit 4 picks low or high active
// R8: Bit 3 picks open-drain or push-pull drive
// R9: Bits 2..0 enable link, packet, address
// R10: Level holds until status cleared or reset
module wrp_wake_signaler #(
  parameter int PULSE_SHORT_CYCLES = wrp_pkg::PULSE_SHORT_CYC,
  parameter int PULSE_LONG_CYCLES = wrp_pkg::PULSE_LONG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wrp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wrp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wakeup_pin,
  input wire logic packet_event,
  input wire logic wake_frame_filter_match,
  input wire logic exact_dest_addr_match,
  input wire logic phy_link_change,
  output logic wake_request_out_o,
  output logic wake_request_out_oe,
  output logic irq
);
  import wrp_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0] cfg_reg;
  logic [SRC_N-1:0] status_reg;
  logic [SRC_N-1:0] status_next;
  logic [SRC_N-1:0] int_en_reg;
  logic [SRC_N-1:0] clear_mask;
  logic [SRC_N-1:0] events;
  logic master_en;
  logic pin_level;
  logic pin_prev_reg;
  logic pin_event;
  logic pulse_start;
  logic pulse_active;
  logic wake_active;
  logic out_next;
  logic oe_next;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [CNT_W-1:0] short_cnt;
  logic [CNT_W-1:0] long_cnt;

  // ==========================================================
  // Helpers
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFS_CONFIG) || (a == OFS_STATUS) ||
                  (a == OFS_CLEAR) || (a == OFS_ENABLE) ||
                  (a == OFS_STATE);
  endfunction

  // ==========================================================
  // Wakeup pin comes from outside the clock domain
  wrp_pin_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async(wakeup_pin),
    .pin_level(pin_level)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_level;
    end
  end

  assign pin_event = pin_level && !pin_prev_reg;

  // ==========================================================
  // Event qualification
  // R1: master enable gate
  assign master_en = cfg_reg[CFG_MASTER_BIT];

  // R2: all five sources feed the wake
  // R9: enables for link, packet and address only, all masked by master
  always_comb begin
    events = '0;
    events[SRC_PIN] = pin_event;
    events[SRC_PKT] = packet_event && cfg_reg[CFG_PKT_EN_BIT];
    events[SRC_WFF] = wake_frame_filter_match;
    events[SRC_DA] = exact_dest_addr_match && cfg_reg[CFG_DA_EN_BIT];
    events[SRC_LINK] = phy_link_change && cfg_reg[CFG_LINK_EN_BIT];
    if (!master_en) begin
      events = '0;
    end
  end

  // ==========================================================
  // Sticky status, set wins over a same-cycle clear
  always_comb begin
    clear_mask = '0;
    if (wr_fire && (wr_addr == OFS_CLEAR) && wr_strb[0]) begin
      clear_mask = wr_data[SRC_N-1:0];
    end
    status_next = (status_reg & ~clear_mask) | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & int_en_reg);
    end
  end

  // ==========================================================
  // Pulse timing
  assign short_cnt = CNT_W'(PULSE_SHORT_CYCLES);
  assign long_cnt = CNT_W'(PULSE_LONG_CYCLES);

  // R4: pulse style starts the one-shot
  assign pulse_start = master_en && cfg_reg[CFG_PULSE_BIT] && (|events);

  // R5: length select at start
  // R6: retrigger ignored inside the timer
  wrp_pulse_timer u_pulse_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(pulse_start),
    .long_sel(cfg_reg[CFG_LONG_BIT]),
    .short_cycles(short_cnt),
    .long_cycles(long_cnt),
    .active(pulse_active)
  );

  // ==========================================================
  // Output pin
  // R10: level style follows the sticky status
  // R3: master off forces inactive and released
  assign wake_active = master_en &&
    (cfg_reg[CFG_PULSE_BIT] ? pulse_active : (|status_reg));

  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b0;
    if (master_en) begin
      // R7: polarity of level and pulse
      out_next = wake_active ? cfg_reg[CFG_POL_BIT] :
                 !cfg_reg[CFG_POL_BIT];
      // R8: open drain drives only the active state
      oe_next = cfg_reg[CFG_PUSHPULL_BIT] || wake_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_request_out_o <= 1'b0;
      wake_request_out_oe <= 1'b0;
    end else begin
      wake_request_out_o <= out_next;
      wake_request_out_oe <= oe_next;
    end
  end

  // ==========================================================
  // AXI4-Lite write path, address and data in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // Commit one cycle after both halves are held
  assign wr_fire = aw_held_reg && w_held_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Writable registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_fire && (wr_addr == OFS_CONFIG) && wr_strb[0]) begin
      cfg_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en_reg <= ENABLE_RESET;
    end else if (wr_fire && (wr_addr == OFS_ENABLE) && wr_strb[0]) begin
      int_en_reg <= wr_data[SRC_N-1:0];
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_CONFIG: rd_word[7:0] = cfg_reg;
      OFS_STATUS: rd_word[SRC_N-1:0] = status_reg;
      OFS_ENABLE: rd_word[SRC_N-1:0] = int_en_reg;
      OFS_STATE: begin
        rd_word[ST_ACTIVE_BIT] = wake_active;
        rd_word[ST_PULSE_BIT] = pulse_active;
        rd_word[ST_PIN_BIT] = pin_level;
      end
      // Clear register is write-only and reads as zero
      OFS_CLEAR: rd_word = '0;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: core/wrp_pkg.sv
// Constants shared by the wake request pin signaler
package wrp_pkg;

  // ==========================================================
  // Register map, byte addresses on the AXI4-Lite slave
  localparam logic [4:0] OFS_CONFIG = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_CLEAR = 5'h08;
  localparam logic [4:0] OFS_ENABLE = 5'h0C;
  localparam logic [4:0] OFS_STATE = 5'h10;
  localparam int ADDR_W = 5;

  // ==========================================================
  // Configuration byte fields
  localparam int CFG_MASTER_BIT = 7;
  localparam int CFG_PULSE_BIT = 6;
  localparam int CFG_LONG_BIT = 5;
  localparam int CFG_POL_BIT = 4;
  localparam int CFG_PUSHPULL_BIT = 3;
  localparam int CFG_LINK_EN_BIT = 2;
  localparam int CFG_PKT_EN_BIT = 1;
  localparam int CFG_DA_EN_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ==========================================================
  // Wake source positions in status, clear and enable
  localparam int SRC_N = 5;
  localparam int SRC_PIN = 0;
  localparam int SRC_PKT = 1;
  localparam int SRC_WFF = 2;
  localparam int SRC_DA = 3;
  localparam int SRC_LINK = 4;
  localparam logic [SRC_N-1:0] STATUS_RESET = 5'h00;
  localparam logic [SRC_N-1:0] ENABLE_RESET = 5'h00;

  // State register bits
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_PULSE_BIT = 1;
  localparam int ST_PIN_BIT = 2;

  // ==========================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Timing
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real PULSE_SHORT_MS = 1.5;
  localparam real PULSE_LONG_MS = 150.0;
  localparam int CNT_W = 24;
  localparam int PULSE_SHORT_CYC = int'(PULSE_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int PULSE_LONG_CYC = int'(PULSE_LONG_MS * 1.0e6 / CLK_PERIOD_NS);

endpackage

// File: core/wrp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module wrp_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_async,
  output logic pin_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ==========================================================
  // Stage one is read only by stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      pin_level <= s3_reg;
    end
  end

endmodule

// File: core/wrp_pulse_timer.sv
// One-shot pulse timer, length chosen at start
`timescale 1ns/1ps
module wrp_pulse_timer
  import wrp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic long_sel,
  input wire logic [wrp_pkg::CNT_W-1:0] short_cycles,
  input wire logic [wrp_pkg::CNT_W-1:0] long_cycles,
  output logic active
);

  logic [CNT_W-1:0] count_reg;

  assign active = (count_reg != '0);

  // Start while running is ignored, so the length never stretches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (start && !active) begin
      count_reg <= long_sel ? long_cycles : short_cycles;
    end else if (active) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule

// File: sim/wrp_wake_checker.sv
// Port-level assertions for the wake request signaler
`timescale 1ns/1ps
module wrp_wake_checker
  import wrp_pkg::*;
#(
  parameter int PULSE_SHORT_CYCLES = 20,
  parameter int PULSE_LONG_CYCLES = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wrp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic wake_frame_filter_match,
  input wire logic wake_request_out_o,
  input wire logic wake_request_out_oe
);
  logic [4:0] a_q;
  logic [8:0] d_q;
  logic [7:0] cfg;
  logic [1:0] stab;
  logic [31:0] cnt;
  logic act;
  assign act = wake_request_out_oe && (wake_request_out_o == cfg[4]);
  // ==========================================================
  // Config shadow; stab blocks checks while a write settles
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cfg <= 8'h00;
    else if (s_axi_bvalid && s_axi_bready && a_q == OFS_CONFIG && d_q[8])
      cfg <= d_q[7:0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || s_axi_awvalid || s_axi_wvalid || s_axi_bvalid)
      stab <= 2'h0;
    else if (stab != 2'h3) stab <= stab + 2'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !act) cnt <= 32'h0;
    else cnt <= cnt + 32'h1;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_master_gate: assert property (
    !cfg[7] && stab == 2'h3 |-> !wake_request_out_oe) else $error("drive off");
  chk_event_drive: assert property (
    cfg[7] && stab == 2'h3 && wake_frame_filter_match |-> ##[1:3] act)
    else $error("no wake");
  chk_pulse_len: assert property (
    !act && $past(act) && stab == 2'h3 && cfg[7] && cfg[6]
    |-> cnt == PULSE_SHORT_CYCLES || cnt == PULSE_LONG_CYCLES)
    else $error("pulse length");
  chk_od_pol: assert property (
    cfg[7] && !cfg[3] && stab == 2'h3 && wake_request_out_oe
    |-> wake_request_out_o == cfg[4]) else $error("open drain level");
  chk_pp_drive: assert property (
    cfg[7] && cfg[3] && stab == 2'h3 |-> wake_request_out_oe)
    else $error("push pull drive");
  chk_level_hold: assert property (
    cfg[7] && !cfg[6] && stab == 2'h3 && act |=> act) else $error("level drop");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  chk_rd_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("wr late");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (!act && $past(act) && cfg[6]);
  cover property (act && !cfg[6]);
endmodule

bind wrp_wake_signaler wrp_wake_checker #(
  .PULSE_SHORT_CYCLES(PULSE_SHORT_CYCLES),
  .PULSE_LONG_CYCLES(PULSE_LONG_CYCLES)
) wrp_wake_checker_inst (.*);

// File: sim/wrp_host_wake.sv
// Host platform wake input: resolves the wake line with its pull
`timescale 1ns/1ps
module wrp_host_wake (
  input wire logic drive_o,
  input wire logic drive_oe,
  input wire logic pull_level,
  output logic line
);
  // Released line shows the pull, never the last driven value
  assign line = drive_oe ? drive_o : pull_level;
endmodule

// File: sim/testbench.sv
// Self-checking bench for the wake request signaler
`timescale 1ns/1ps
module testbench;
  import wrp_pkg::*;
  localparam int SHORT_N = 20;
  localparam int LONG_N = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, pull = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wake_request_out_o, wake_request_out_oe, irq, line;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] ev = 5'h00;
  integer num_errors = 0, n_checks = 0, cyc = 0, act_n = 0;
  integer seed = 32'heffa, cfg = 0, status = 0, ien = 0;
  always #5 aclk = ~aclk;
  wrp_wake_signaler #(.PULSE_SHORT_CYCLES(SHORT_N),
    .PULSE_LONG_CYCLES(LONG_N)) wrp_wake_signaler_inst (.*,
    .wakeup_pin(ev[SRC_PIN]), .packet_event(ev[SRC_PKT]),
    .wake_frame_filter_match(ev[SRC_WFF]),
    .exact_dest_addr_match(ev[SRC_DA]), .phy_link_change(ev[SRC_LINK]));
  wrp_host_wake wrp_host_wake_inst (.drive_o(wake_request_out_o),
    .drive_oe(wake_request_out_oe), .pull_level(pull), .line(line));
  // ==========================================================
  // Bus, compare and model tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic line_exp();
    if (!cfg[CFG_MASTER_BIT]) return pull;
    if (status != 0 && !cfg[CFG_PULSE_BIT]) return cfg[CFG_POL_BIT];
    return cfg[CFG_PUSHPULL_BIT] ? !cfg[CFG_POL_BIT] : pull;
  endfunction
  task automatic fire(input int s);
    @(posedge aclk);
    ev[s] <= 1'b1;
    // Pin passes a filter, so it needs a long hold
    repeat (s == SRC_PIN ? 8 : 1) @(posedge aclk);
    ev[s] <= 1'b0;
    if (cfg[7] && (s == SRC_PIN || s == SRC_WFF || (s == SRC_PKT && cfg[1])
        || (s == SRC_DA && cfg[0]) || (s == SRC_LINK && cfg[2])))
      status = status | (1 << s);
    repeat (8) @(posedge aclk);
  endtask
  task automatic setcfg(input logic [7:0] c);
    cfg = c;
    pull <= !c[CFG_POL_BIT];
    axw(OFS_CONFIG, {24'h0, c});
    axw(OFS_CLEAR, 32'h1F);
    status = 0;
  endtask
  task automatic look();
    axr(OFS_STATUS);
    chk("status", status, rd);
    chk("irq", {31'h0, (status & ien) != 0}, {31'h0, irq});
    chk("line", {31'h0, line_exp()}, {31'h0, line});
    axr(OFS_STATE);
    chk("state", {31'h0, cfg[7] && !cfg[6] && status != 0}, rd);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (line === cfg[CFG_POL_BIT]) act_n++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      axr(a[4:0]);
      chk("reset data", 32'h0, rd);
      chk("read resp", a == 20 ? RESP_SLVERR : RESP_OKAY, {30'h0, rsp});
    end
    axw(5'h14, 32'hFF);
    chk("unmapped resp", RESP_SLVERR, {30'h0, rsp});
    ien = 31;
    axw(OFS_ENABLE, 32'h1F);
    axw(OFS_STATUS, 32'h1F);
    setcfg(8'h7F);
    for (int s = 0; s < 5; s++) fire(s);
    look();
    for (int m = 0; m < 4; m++) begin
      ien = $random(seed) & 31;
      axw(OFS_ENABLE, ien);
      setcfg(8'h80 | (m << 3) | ($random(seed) & 7));
      for (int s = 0; s < 5; s++) begin
        fire(s);
        look();
      end
      axw(OFS_CLEAR, 32'h1F);
      status = 0;
      repeat (4) @(posedge aclk);
      look();
    end
    for (int l = 0; l < 2; l++) begin
      setcfg(8'hD0 | (l << 5));
      act_n = 0;
      fire(SRC_WFF);
      fire(SRC_PIN);
      repeat (60) @(posedge aclk);
      chk("pulse len", l ? LONG_N : SHORT_N, act_n);
    end
    final_report();
  end
endmodule
